// ### core/dcd_pkg.sv
package dcd_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [13:0] DCD_OFS_CTRL = 14'h1c00;
	localparam logic [13:0] DCD_OFS_BLUE = 14'h1cfc;
	localparam logic [13:0] DCD_OFS_SLOT_FIRST = 14'h1e80;
	localparam logic [13:0] DCD_OFS_SLOT_LAST = 14'h1ebc;
	localparam logic [13:0] DCD_OFS_MAP_FIRST = 14'h1e30;
	localparam logic [13:0] DCD_OFS_MAP_LAST = 14'h1e3c;
	localparam logic [13:0] DCD_DRAW_BASE = 14'h1c00;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [31:0] DCD_CTRL_RST = 32'h0000_0000;
	localparam logic [23:0] DCD_BLUE_RST = 24'h00_0000;
	localparam logic [7:0] DCD_MAP_RST = 8'h00;
	localparam int DCD_OPC_LSB = 0;
	localparam int DCD_ATY_LSB = 4;
	localparam int DCD_LIN_BIT = 7;
	localparam int DCD_ZM_LSB = 8;
	localparam int DCD_SOLID_BIT = 11;
	localparam int DCD_ARZ_BIT = 12;
	localparam int DCD_SGNZ_BIT = 13;
	localparam int DCD_SHZ_BIT = 14;
	localparam int DCD_BOP_LSB = 16;
	localparam int DCD_TRN_LSB = 20;
	localparam int DCD_BLT_LSB = 25;
	localparam int DCD_PAT_BIT = 29;
	localparam int DCD_KEY_BIT = 30;
	localparam int DCD_BLUE_W = 24;
	localparam logic [6:0] DCD_EDGE_CLR = 7'h77;
	localparam logic [3:0] DCD_BOP_SRC = 4'hc;
	// Screen-door thresholds, one nibble per cell, index {y, x}.
	localparam logic [63:0] DCD_DOOR = 64'h5d7f_91b3_6e4c_a280;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	typedef enum logic [3:0] {
		DCD_OP_LINE_OPEN = 4'h0, DCD_OP_AUTO_OPEN = 4'h1,
		DCD_OP_LINE_CLOSE = 4'h2, DCD_OP_AUTO_CLOSE = 4'h3,
		DCD_OP_TRAP = 4'h4, DCD_OP_HOST_FED_FILL = 4'h5,
		DCD_OP_LOAD_HQ = 4'h7, DCD_OP_COPY_BLIT = 4'h8,
		DCD_OP_HOST_IMAGE_LOAD = 4'h9, DCD_OP_READBACK = 4'ha,
		DCD_OP_RSV = 4'hb, DCD_OP_FAST_COPY = 4'hc,
		DCD_OP_LOAD_SCALE = 4'hd, DCD_OP_LOAD_HQ_HV = 4'he,
		DCD_OP_LOAD_FILTER = 4'hf
	} dcd_opc_t;
	typedef enum logic [2:0] {
		DCD_AT_REPLACE_WRITE = 3'h0, DCD_AT_READ_MODIFY_WRITE = 3'h1,
		DCD_AT_RSV2 = 3'h2, DCD_AT_DEPTH_SHADE = 3'h3,
		DCD_AT_BLOCK_WRITE = 3'h4, DCD_AT_RSV5 = 3'h5,
		DCD_AT_RSV6 = 3'h6, DCD_AT_SHADE_ZCMP = 3'h7
	} dcd_atype_t;
	typedef enum logic [2:0] {
		DCD_ZM_ALWAYS = 3'h0, DCD_ZM_RSV = 3'h1, DCD_ZM_EQ = 3'h2,
		DCD_ZM_NE = 3'h3, DCD_ZM_LT = 3'h4, DCD_ZM_LE = 3'h5,
		DCD_ZM_GT = 3'h6, DCD_ZM_GE = 3'h7
	} dcd_zmode_t;
	typedef enum logic [3:0] {
		DCD_SF_MONO_LE = 4'h0, DCD_SF_PLANE = 4'h1,
		DCD_SF_FORMATTED_COLOR_SOURCE = 4'h2, DCD_SF_BGR32 = 4'h3,
		DCD_SF_MONO_HOST = 4'h4, DCD_SF_RGB32 = 4'h7,
		DCD_SF_BGR24 = 4'hb, DCD_SF_YUV = 4'he, DCD_SF_RGB24 = 4'hf
	} dcd_srcfmt_t;

	typedef struct packed {
		logic [3:0] bop;
		logic ztest;
		logic zwrite;
		logic fclip;
		logic pat;
		logic cexp;
		logic bgwr;
		logic transp;
		logic rsv;
	} dcd_flags_t;

endpackage : dcd_pkg

// ### core/dcd_rop.sv
`timescale 1ns/1ps
module dcd_rop
	import dcd_pkg::*;
#(
	parameter int W = 32
) (
	input wire logic [3:0] bop,
	input wire logic [W-1:0] dst,
	input wire logic [W-1:0] src,
	output logic [W-1:0] res
);

	// ****************************************************************
	// Per-bit two-input function
	// ****************************************************************
	// The function code is itself the truth table, index {S, D}.
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign res[i] = bop[{src[i], dst[i]}];
	end

endmodule : dcd_rop

// ### core/dcd_top.sv
`timescale 1ns/1ps
// What this block does
// - Decode operation code in bits 3:0.
// - Decode memory access type in bits 6:4.
// - Block write forces replace, ignoring logic function.
// - Depth-compare shading gates writes, never writes depth.
// - Bit 7 selects x-y or linear blit.
// - Bits 10:8 choose depth comparison for updates.
// - Bit 11 loads source pattern words all ones.
// - Bit 12 clears edge registers except register three.
// - Bit 13 clears every direction flag.
// - Bit 14 clears shifter; zero leaves it.
// - Bits 19:16 pick sixteen destination/source functions.
// - Bits 23:20 pick screen-door opacity pattern.
// - Decode blit source format in bits 28:25.
// - Formatted-colour memory copy enables fast clipping.
// - Bit 29 enables patterning during copy blits.
// - Bit 30 honoured for blits, styled lines, fills.
// - Colour expansion writes background only when key clear.
// - Keyed blit skips when masked source equals key.
// - Sixteen write-only slots forward through mapping bytes.
// - Target is drawing base plus mapping byte.
// - Blue step holds signed 24-bit fixed point.
module dcd_top
	import dcd_pkg::*;
#(
	parameter int PW = 32,
	parameter int ZW = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [13:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic pix_valid,
	input wire logic [PW-1:0] pix_src,
	input wire logic [PW-1:0] pix_dst,
	input wire logic [ZW-1:0] pix_z_new,
	input wire logic [ZW-1:0] pix_z_old,
	input wire logic [1:0] pix_x,
	input wire logic [1:0] pix_y,
	input wire logic pix_is_bg,
	input wire logic [PW-1:0] key_value,
	input wire logic [PW-1:0] key_mask,
	output logic fwd_valid,
	output logic [13:0] fwd_addr,
	output logic [31:0] fwd_data,
	output logic src_ones_load,
	output logic [6:0] edge_clear,
	output logic dir_clear,
	output logic shift_clear,
	output logic [3:0] opcode,
	output logic [2:0] access_type,
	output logic linear_mode,
	output logic [2:0] depth_mode,
	output logic [3:0] logic_func,
	output logic [3:0] opacity,
	output logic [3:0] src_format,
	output logic pattern_en,
	output logic fast_clip_en,
	output logic depth_test_en,
	output logic depth_write_en,
	output logic bg_write_en,
	output logic transp_en,
	output logic code_reserved,
	output logic [23:0] blue_y_step,
	output logic out_valid,
	output logic out_write,
	output logic [PW-1:0] out_data,
	output logic out_z_write
);

	if (PW < 1 || PW > 32) begin : g_chk_pw
		$error("dcd_top: PW must lie in 1..32");
	end
	if (ZW < 1 || ZW > 32) begin : g_chk_zw
		$error("dcd_top: ZW must lie in 1..32");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [31:0] ctrl;
		dcd_flags_t fl;
		logic [DCD_BLUE_W-1:0] blue;
		logic [15:0][7:0] map;
		logic fwd_v;
		logic [13:0] fwd_a;
		logic [31:0] fwd_d;
		logic ones;
		logic [6:0] edge_c;
		logic dir_c;
		logic shift_c;
		logic o_v;
		logic o_w;
		logic [PW-1:0] o_d;
		logic o_zw;
	} dcd_state_t;

	function automatic dcd_flags_t dcd_derive(input logic [31:0] c);
		dcd_flags_t f;
		logic [3:0] opc;
		logic [2:0] at;
		logic [3:0] bm;
		opc = c[DCD_OPC_LSB +: 4];
		at = c[DCD_ATY_LSB +: 3];
		bm = c[DCD_BLT_LSB +: 4];
		f.bop = c[DCD_BOP_LSB +: 4];
		if (at == DCD_AT_BLOCK_WRITE) begin
			f.bop = DCD_BOP_SRC;
		end
		f.ztest = at == DCD_AT_DEPTH_SHADE || at == DCD_AT_SHADE_ZCMP;
		f.zwrite = at == DCD_AT_DEPTH_SHADE;
		f.fclip = opc == DCD_OP_COPY_BLIT &&
			bm == DCD_SF_FORMATTED_COLOR_SOURCE;
		f.pat = c[DCD_PAT_BIT] && (opc == DCD_OP_COPY_BLIT ||
			opc == DCD_OP_FAST_COPY);
		f.cexp = bm == DCD_SF_MONO_LE || bm == DCD_SF_MONO_HOST ||
			bm == DCD_SF_PLANE;
		f.bgwr = !(f.cexp && c[DCD_KEY_BIT]);
		f.transp = c[DCD_KEY_BIT] && (opc[3] || opc == DCD_OP_TRAP ||
			opc == DCD_OP_HOST_FED_FILL || (opc < DCD_OP_TRAP &&
			bm == DCD_SF_FORMATTED_COLOR_SOURCE));
		case (bm)
			DCD_SF_MONO_LE, DCD_SF_PLANE, DCD_SF_FORMATTED_COLOR_SOURCE,
			DCD_SF_BGR32, DCD_SF_MONO_HOST, DCD_SF_RGB32, DCD_SF_BGR24,
			DCD_SF_YUV, DCD_SF_RGB24: f.rsv = 1'b0;
			default: f.rsv = 1'b1;
		endcase
		if (opc == DCD_OP_RSV || at == DCD_AT_RSV2 || at == DCD_AT_RSV5 ||
			at == DCD_AT_RSV6 || c[DCD_ZM_LSB +: 3] == DCD_ZM_RSV) begin
			f.rsv = 1'b1;
		end
		return f;
	endfunction : dcd_derive

	localparam dcd_state_t DCD_ST_RST = '{
		ctrl: DCD_CTRL_RST,
		fl: dcd_derive(DCD_CTRL_RST),
		blue: DCD_BLUE_RST,
		map: {16{DCD_MAP_RST}},
		default: '0
	};

	dcd_state_t state_reg;
	dcd_state_t state_next;
	logic [1:0] src_v;
	logic [1:0][13:0] src_a;
	logic [1:0][31:0] src_d;
	logic [PW-1:0] rop_res;
	logic z_pass;
	logic door_open;
	logic skip;

	// ****************************************************************
	// Pixel helpers
	// ****************************************************************
	dcd_rop #(
		.W(PW)
	) u_rop (
		.bop(state_reg.fl.bop),
		.dst(pix_dst),
		.src(pix_src),
		.res(rop_res)
	);

	dcd_zgate #(
		.ZW(ZW)
	) u_zgate (
		.zmode(state_reg.ctrl[DCD_ZM_LSB +: 3]),
		.z_new(pix_z_new),
		.z_old(pix_z_old),
		.trans(state_reg.ctrl[DCD_TRN_LSB +: 4]),
		.px(pix_x),
		.py(pix_y),
		.z_pass(z_pass),
		.opaque(door_open)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	// The forwarded write lands first so that a direct write to the
	// same register in the same cycle, being newer, wins.
	assign src_v = {wr_en, state_reg.fwd_v};
	assign src_a = {wr_addr, state_reg.fwd_a};
	assign src_d = {wr_data, state_reg.fwd_d};

	assign skip = (!state_reg.fl.bgwr && pix_is_bg) ||
		(!state_reg.fl.cexp && state_reg.fl.transp &&
		((pix_src & key_mask) == key_value));

	always_comb begin
		state_next = state_reg;
		state_next.fwd_v = 1'b0;
		state_next.ones = 1'b0;
		state_next.edge_c = '0;
		state_next.dir_c = 1'b0;
		state_next.shift_c = 1'b0;
		for (int k = 0; k < 2; k++) begin
			if (src_v[k] && src_a[k] == DCD_OFS_CTRL) begin
				state_next.ctrl = src_d[k];
				if (src_d[k][DCD_SOLID_BIT]) begin
					state_next.ones = 1'b1;
				end
				if (src_d[k][DCD_ARZ_BIT]) begin
					state_next.edge_c = DCD_EDGE_CLR;
				end
				if (src_d[k][DCD_SGNZ_BIT]) begin
					state_next.dir_c = 1'b1;
				end
				if (src_d[k][DCD_SHZ_BIT]) begin
					state_next.shift_c = 1'b1;
				end
			end
			if (src_v[k] && src_a[k] == DCD_OFS_BLUE) begin
				state_next.blue = src_d[k][DCD_BLUE_W-1:0];
			end
		end
		// Mapping and slots are reached only directly; forwarded targets
		// stay below them, so a forward can never forward again.
		if (wr_en && wr_addr >= DCD_OFS_MAP_FIRST &&
			wr_addr <= DCD_OFS_MAP_LAST && wr_addr[1:0] == 2'b00) begin
			for (int b = 0; b < 4; b++) begin
				state_next.map[{wr_addr[3:2], 2'(b)}] = wr_data[8*b +: 8];
			end
		end
		if (wr_en && wr_addr >= DCD_OFS_SLOT_FIRST &&
			wr_addr <= DCD_OFS_SLOT_LAST && wr_addr[1:0] == 2'b00) begin
			state_next.fwd_v = 1'b1;
			state_next.fwd_a = DCD_DRAW_BASE +
				{6'h00, state_reg.map[wr_addr[5:2]]};
			state_next.fwd_d = wr_data;
		end
		state_next.fl = dcd_derive(state_next.ctrl);
		state_next.o_v = pix_valid;
		state_next.o_w = pix_valid && door_open && !skip &&
			(!state_reg.fl.ztest || z_pass) && !state_reg.fl.rsv;
		state_next.o_d = rop_res;
		state_next.o_zw = state_next.o_w && state_reg.fl.zwrite;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= DCD_ST_RST;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign fwd_valid = state_reg.fwd_v;
	assign fwd_addr = state_reg.fwd_a;
	assign fwd_data = state_reg.fwd_d;
	assign src_ones_load = state_reg.ones;
	assign edge_clear = state_reg.edge_c;
	assign dir_clear = state_reg.dir_c;
	assign shift_clear = state_reg.shift_c;
	assign opcode = state_reg.ctrl[DCD_OPC_LSB +: 4];
	assign access_type = state_reg.ctrl[DCD_ATY_LSB +: 3];
	assign linear_mode = state_reg.ctrl[DCD_LIN_BIT];
	assign depth_mode = state_reg.ctrl[DCD_ZM_LSB +: 3];
	assign logic_func = state_reg.fl.bop;
	assign opacity = state_reg.ctrl[DCD_TRN_LSB +: 4];
	assign src_format = state_reg.ctrl[DCD_BLT_LSB +: 4];
	assign pattern_en = state_reg.fl.pat;
	assign fast_clip_en = state_reg.fl.fclip;
	assign depth_test_en = state_reg.fl.ztest;
	assign depth_write_en = state_reg.fl.zwrite;
	assign bg_write_en = state_reg.fl.bgwr;
	assign transp_en = state_reg.fl.transp;
	assign code_reserved = state_reg.fl.rsv;
	assign blue_y_step = state_reg.blue;
	assign out_valid = state_reg.o_v;
	assign out_write = state_reg.o_w;
	assign out_data = state_reg.o_d;
	assign out_z_write = state_reg.o_zw;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic ctrl_wr;
	logic slot_wr;
	assign ctrl_wr = ce && wr_en && wr_addr == DCD_OFS_CTRL;
	assign slot_wr = ce && wr_en && wr_addr >= DCD_OFS_SLOT_FIRST &&
		wr_addr <= DCD_OFS_SLOT_LAST && wr_addr[1:0] == 2'b00;

	chk_opc_load: assert property (
		ctrl_wr |=> opcode == $past(wr_data[3:0]))
		else $error("opcode not taken from control write");
	chk_atype_load: assert property (
		ctrl_wr |=> access_type == $past(wr_data[6:4]))
		else $error("access type not taken from control write");
	chk_block_src: assert property (
		access_type == DCD_AT_BLOCK_WRITE |-> logic_func == DCD_BOP_SRC)
		else $error("block write does not force replace");
	chk_zcmp_nowrite: assert property (
		ce && !depth_write_en |=> !out_z_write)
		else $error("depth written while depth write is off");
	chk_linear_bit: assert property (
		ctrl_wr |=> linear_mode == $past(wr_data[7]))
		else $error("linear bit not taken");
	chk_zeq_gate: assert property (
		ce && pix_valid && depth_test_en && depth_mode == DCD_ZM_EQ &&
		pix_z_new != pix_z_old |=> !out_write)
		else $error("equal compare let a differing depth through");
	chk_solid_pulse: assert property (
		ctrl_wr && wr_data[DCD_SOLID_BIT] |=> src_ones_load)
		else $error("all-ones load not pulsed");
	chk_edge_mask: assert property (
		ctrl_wr && wr_data[DCD_ARZ_BIT] |=> edge_clear == DCD_EDGE_CLR)
		else $error("edge clear mask wrong");
	chk_dir_clear: assert property (
		ctrl_wr && wr_data[DCD_SGNZ_BIT] |=> dir_clear)
		else $error("direction clear not pulsed");
	chk_shift_keep: assert property (
		ce && !fwd_valid && !(ctrl_wr && wr_data[DCD_SHZ_BIT])
		|=> !shift_clear)
		else $error("shifter cleared without request");
	chk_door_one: assert property (
		ce && pix_valid && opacity == 4'hf && {pix_y, pix_x} != 4'hc
		|=> !out_write)
		else $error("opacity fifteen wrote a masked cell");
	chk_fast_clip: assert property (
		ctrl_wr ##1 opcode == DCD_OP_COPY_BLIT &&
		src_format == DCD_SF_FORMATTED_COLOR_SOURCE |-> fast_clip_en)
		else $error("fast clipping not enabled");
	chk_key_skip: assert property (
		ce && pix_valid && transp_en && !bg_write_en == 1'b0 &&
		src_format == DCD_SF_BGR32 &&
		(pix_src & key_mask) == key_value |=> !out_write)
		else $error("keyed pixel was written");
	chk_slot_fwd: assert property (
		slot_wr |=> fwd_valid && fwd_addr == DCD_DRAW_BASE +
		{6'h00, $past(state_reg.map[wr_addr[5:2]])} ##1
		(!fwd_valid || $past(slot_wr || !ce)))
		else $error("slot forward address wrong");
	chk_blue_load: assert property (
		ce && wr_en && wr_addr == DCD_OFS_BLUE
		|=> blue_y_step == $past(wr_data[23:0]))
		else $error("blue step not loaded");

	cov_slot_fwd: cover property (slot_wr ##1 fwd_valid);
	cov_block: cover property (out_write &&
		access_type == DCD_AT_BLOCK_WRITE);
	cov_zcmp: cover property (out_write &&
		access_type == DCD_AT_SHADE_ZCMP);
	cov_rsv: cover property (code_reserved ##1 !code_reserved);

endmodule : dcd_top

// ### core/dcd_zgate.sv
`timescale 1ns/1ps
module dcd_zgate
	import dcd_pkg::*;
#(
	parameter int ZW = 16
) (
	input wire logic [2:0] zmode,
	input wire logic [ZW-1:0] z_new,
	input wire logic [ZW-1:0] z_old,
	input wire logic [3:0] trans,
	input wire logic [1:0] px,
	input wire logic [1:0] py,
	output logic z_pass,
	output logic opaque
);

	// ****************************************************************
	// Depth comparison and screen door
	// ****************************************************************
	always_comb begin
		case (dcd_zmode_t'(zmode))
			DCD_ZM_ALWAYS: z_pass = 1'b1;
			DCD_ZM_EQ: z_pass = z_new == z_old;
			DCD_ZM_NE: z_pass = z_new != z_old;
			DCD_ZM_LT: z_pass = z_new < z_old;
			DCD_ZM_LE: z_pass = z_new <= z_old;
			DCD_ZM_GT: z_pass = z_new > z_old;
			DCD_ZM_GE: z_pass = z_new >= z_old;
			// A reserved compare writes nothing rather than guessing.
			default: z_pass = 1'b0;
		endcase
	end

	// A cell is written when its threshold reaches the opacity code.
	assign opaque = DCD_DOOR[{py, px, 2'b00} +: 4] >= trans;

endmodule : dcd_zgate

// ### tb/dcd_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host software model writing drawing registers
// ****************************************************************
module dcd_host
	import dcd_pkg::*;
(
	input wire logic clk,
	output logic wr_en,
	output logic [13:0] wr_addr,
	output logic [31:0] wr_data
);
	logic strict = 1'b1;

	initial begin
		wr_en = 1'b0;
		wr_addr = 14'h0000;
		wr_data = 32'h0000_0000;
	end

	// Source and pattern words are never written by this model.
	task automatic write(input logic [13:0] a, input logic [31:0] d,
		input logic last, output logic [31:0] sent);
		sent = d;
		if (strict && a == DCD_OFS_CTRL && d[6:4] == 3'h4) begin
			sent[19:16] = DCD_BOP_SRC;
		end
		if (strict && a == DCD_OFS_CTRL && d[3:2] == 2'h0 && !d[11]) begin
			sent[28:25] = 4'h2;
		end
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = sent;
		@(posedge clk);
		#2;
		// A released bus shows inverted data, so stale values cannot pass.
		if (last) begin
			wr_en = 1'b0;
			wr_data = ~sent;
		end
	endtask : write
endmodule : dcd_host

// ### tb/drawing_control_decode_test.sv
`timescale 1ns/1ps
module drawing_control_decode_test
	import dcd_pkg::*;
;
	logic clk, rstn, ce, wr_en, pv, is_bg;
	logic [13:0] wr_addr, fwd_addr;
	logic [31:0] wr_data, fwd_data, src, dst, key, mask, ctl, rnd, sent, w;
	logic [15:0] zn, zo;
	logic [1:0] px, py;
	logic fwd_valid, src_ones_load, dir_clear, shift_clear, linear_mode;
	logic pattern_en, fast_clip_en, depth_test_en, depth_write_en;
	logic bg_write_en, transp_en, code_reserved, out_valid, out_write;
	logic out_z_write;
	logic [6:0] edge_clear;
	logic [3:0] opcode, logic_func, opacity, src_format;
	logic [2:0] access_type, depth_mode;
	logic [23:0] blue_y_step, blue;
	logic [31:0] out_data;
	logic [7:0] map [16];
	int err_total, comparisons;

	dcd_host u_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data));

	dcd_top u_dut (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .pix_valid(pv),
		.pix_src(src), .pix_dst(dst), .pix_z_new(zn), .pix_z_old(zo),
		.pix_x(px), .pix_y(py), .pix_is_bg(is_bg), .key_value(key),
		.key_mask(mask), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
		.fwd_data(fwd_data), .src_ones_load(src_ones_load),
		.edge_clear(edge_clear), .dir_clear(dir_clear),
		.shift_clear(shift_clear), .opcode(opcode),
		.access_type(access_type), .linear_mode(linear_mode),
		.depth_mode(depth_mode), .logic_func(logic_func),
		.opacity(opacity), .src_format(src_format),
		.pattern_en(pattern_en), .fast_clip_en(fast_clip_en),
		.depth_test_en(depth_test_en), .depth_write_en(depth_write_en),
		.bg_write_en(bg_write_en), .transp_en(transp_en),
		.code_reserved(code_reserved), .blue_y_step(blue_y_step),
		.out_valid(out_valid), .out_write(out_write),
		.out_data(out_data), .out_z_write(out_z_write));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************************************************************
	// Reference model and checks
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] r);
		return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
	endfunction : lfsr

	function automatic logic rsv(input logic [31:0] c);
		return c[3:0] == 4'hb || c[6:4] inside {3'h2, 3'h5, 3'h6} ||
			c[10:8] == 3'h1 || c[28:25] inside {4'h5, 4'h6, 4'h8, 4'h9,
			4'ha, 4'hc, 4'hd};
	endfunction : rsv

	function automatic logic [31:0] rop(input logic [3:0] f,
		input logic [31:0] d, s);
		case (f)
			4'h0: return 32'h0000_0000;
			4'h1: return ~(d | s);
			4'h2: return d & ~s;
			4'h3: return ~s;
			4'h4: return ~d & s;
			4'h5: return ~d;
			4'h6: return d ^ s;
			4'h7: return ~(d & s);
			4'h8: return d & s;
			4'h9: return ~(d ^ s);
			4'ha: return d;
			4'hb: return d | ~s;
			4'hc: return s;
			4'hd: return ~d | s;
			4'he: return d | s;
			default: return 32'hffff_ffff;
		endcase
	endfunction : rop

	task automatic cmp(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	task automatic complete_run();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic wr(input logic [13:0] a, input logic [31:0] d,
		input logic last);
		u_host.write(a, d, last, sent);
		if (a == DCD_OFS_CTRL && ce) ctl = sent;
		if (a == DCD_OFS_BLUE && ce) blue = sent[23:0];
	endtask : wr

	task automatic chk_ctl();
		logic [3:0] op, sf;
		op = ctl[3:0];
		sf = ctl[28:25];
		cmp("opcode", op, opcode);
		cmp("access_type", ctl[6:4], access_type);
		cmp("linear_mode", ctl[7], linear_mode);
		cmp("depth_mode", ctl[10:8], depth_mode);
		cmp("logic_func", ctl[6:4] == 3'h4 ? 4'hc : ctl[19:16],
			logic_func);
		cmp("opacity", ctl[23:20], opacity);
		cmp("src_format", sf, src_format);
		cmp("pattern_en", ctl[29] & (op == 4'h8 || op == 4'hc),
			pattern_en);
		cmp("fast_clip_en", op == 4'h8 && sf == 4'h2, fast_clip_en);
		cmp("depth_test_en", ctl[5:4] == 2'h3, depth_test_en);
		cmp("depth_write_en", ctl[6:4] == 3'h3, depth_write_en);
		cmp("transp_en", ctl[30] & (op[3] | op[3:1] == 3'h2 |
			(op[3:2] == 2'h0 & sf == 4'h2)), transp_en);
		cmp("bg_write_en", !(ctl[30] && sf inside {4'h0, 4'h1, 4'h4}),
			bg_write_en);
		cmp("code_reserved", rsv(ctl), code_reserved);
	endtask : chk_ctl

	task automatic pix();
		logic [3:0] f, thr;
		logic [31:0] r;
		logic cx, tr, zc, sk, wo;
		rnd = lfsr(rnd);
		pv = rnd[0] | rnd[1];
		px = rnd[3:2];
		py = rnd[5:4];
		src = lfsr(rnd);
		dst = ~rnd;
		mask = {rnd[15:0], rnd[31:16]};
		key = rnd[6] ? (src & mask) : rnd;
		zn = rnd[15:0];
		zo = rnd[8] ? rnd[15:0] : rnd[31:16];
		f = ctl[6:4] == 3'h4 ? DCD_BOP_SRC : ctl[19:16];
		cx = ctl[28:25] inside {4'h0, 4'h1, 4'h4};
		is_bg = cx & rnd[7];
		tr = ctl[30] & (ctl[3] | ctl[3:1] == 3'h2 |
			(ctl[3:2] == 2'h0 & ctl[28:25] == 4'h2));
		thr = DCD_DOOR[{py, px, 2'h0} +: 4];
		case (ctl[10:8])
			3'h2: zc = zn == zo;
			3'h3: zc = zn != zo;
			3'h4: zc = zn < zo;
			3'h5: zc = zn <= zo;
			3'h6: zc = zn > zo;
			3'h7: zc = zn >= zo;
			default: zc = 1'b1;
		endcase
		sk = (ctl[30] & is_bg) | (!cx & tr & ((src & mask) == key));
		wo = pv & (thr >= ctl[23:20]) & !sk & (ctl[5:4] != 2'h3 | zc) &
			!rsv(ctl);
		r = rop(f, dst, src);
		@(posedge clk);
		#2;
		cmp("out_valid", pv, out_valid);
		cmp("out_write", wo, out_write);
		cmp("out_z_write", wo & ctl[6:4] == 3'h3, out_z_write);
		if (pv) cmp("out_data", r, out_data);
	endtask : pix

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		{pv, is_bg, px, py, src, dst, key, mask, zn, zo} = '0;
		rnd = 32'hee9f3a9f;
		ctl = 32'h0000_0000;
		blue = 24'h00_0000;
		err_total = 0;
		comparisons = 0;
		repeat (2) @(posedge clk);
		#2;
		chk_ctl();
		cmp("blue_y_step", blue, blue_y_step);
		rstn = 1'b1;
		@(posedge clk);
		#2;
		for (int i = 0; i < 3; i++) begin
			w = (i == 0) ? 32'h0000_3800 : (i == 1) ? 32'h0000_4000 : 0;
			wr(DCD_OFS_CTRL, w, i == 2);
			cmp("ones", w[11], src_ones_load);
			cmp("edge_clear", w[12] ? DCD_EDGE_CLR : 7'h00,
				edge_clear);
			cmp("dir_clear", w[13], dir_clear);
			cmp("shift_clear", w[14], shift_clear);
		end
		@(posedge clk);
		#2;
		cmp("pulses", 0, {src_ones_load, edge_clear, dir_clear,
			shift_clear});
		for (int n = 0; n < 48; n++) begin
			rnd = lfsr(rnd);
			w = rnd & 32'h7eff_7fff;
			w[3:0] = n[3:0];
			w[6:4] = n[2:0];
			// Opcode 0110 has no defined meaning, so it is steered away.
			if (w[3:0] == 4'h6) w[3:0] = 4'h7;
			if (n % 2 == 1) begin
				if (w[10:8] == 3'h1) w[10:8] = 3'h0;
				if (w[6:4] == 3'h5) w[6:4] = 3'h3;
				if (rsv({3'h0, w[28:25], 25'h0})) w[28:25] = 4'h2;
				if (w[3:0] == 4'hb) w[3:0] = 4'h8;
			end
			u_host.strict = n % 4 != 0;
			wr(DCD_OFS_CTRL, w, 1'b1);
			chk_ctl();
			repeat (4) pix();
		end
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			for (int b = 0; b < 4; b++) begin
				map[4 * k + b] = rnd[8 * b +: 8];
				if (map[4 * k + b] inside {8'h00, 8'hfc})
					map[4 * k + b] = 8'h40;
				if (4 * k + b == 15) map[15] = 8'hfc;
			end
			wr(DCD_OFS_MAP_FIRST + 14'(4 * k), {map[4 * k + 3],
				map[4 * k + 2], map[4 * k + 1], map[4 * k]}, 1'b0);
		end
		for (int s = 0; s < 16; s++) begin
			rnd = lfsr(rnd);
			wr(DCD_OFS_SLOT_FIRST + 14'(4 * s), rnd, s == 15);
			cmp("fwd_valid", 1, fwd_valid);
			cmp("fwd_addr", DCD_DRAW_BASE + 14'(map[s]), fwd_addr);
			cmp("fwd_data", rnd, fwd_data);
		end
		@(posedge clk);
		#2;
		cmp("fwd_valid", 0, fwd_valid);
		cmp("blue_y_step", rnd[23:0], blue_y_step);
		rnd = lfsr(rnd);
		wr(DCD_OFS_BLUE, rnd, 1'b0);
		wr(14'h1c02, ~rnd, 1'b0);
		wr(14'h1c04, ~rnd, 1'b0);
		cmp("blue_y_step", blue, blue_y_step);
		chk_ctl();
		ce = 1'b0;
		wr(DCD_OFS_CTRL, 32'h0000_7823, 1'b1);
		cmp("frozen", 0, {src_ones_load, edge_clear, dir_clear});
		ce = 1'b1;
		chk_ctl();
		complete_run();
	end

	initial begin
		#(50 * 20000);
		err_total++;
		complete_run();
	end
endmodule : drawing_control_decode_test
